// ===== logic/wdt_consts.svh
// Purpose: Offsets, field positions, reset values and counts of the watchdog registers
// Assumes: 32-bit APB, one aligned word per register
// Notes:   Definitions only
`ifndef WDT_CONSTS_SVH
`define WDT_CONSTS_SVH

`define WDT_BASE_ADDR     32'hf000_0000
`define WDT_OFS_ACCESS    32'h0000_0020
`define WDT_OFS_MODE      32'h0000_0024
`define WDT_OFS_STATUS    32'h0000_0028

`define WDT_POS_PROTECT   0
`define WDT_POS_LOCK      1
`define WDT_POS_DIV       2
`define WDT_POS_DIS       3
`define WDT_POS_TIMEOUT   4
`define WDT_POS_PREWARN   5

`define WDT_HW_PASS_HIGH  4'hf
`define WDT_RELOAD_RESET  16'hfffc
`define WDT_TIMEOUT_START 16'hfffc
`define WDT_USER_PW_RESET 8'h00

`define WDT_SLOW_MASK     14'h3fff
`define WDT_FAST_MASK     14'h00ff
`define WDT_PREWARN_CYCLES 12'h800

`endif

// ===== logic/wdt_pkg.sv
// Purpose: Types shared by the watchdog register logic
// Assumes: Constants come from wdt_consts.svh
// Notes:   State travels as packed structs
package wdt_pkg;

  typedef struct packed {
    logic        endinit;
    logic        lock;
    logic [7:0]  user_password;
    logic [15:0] reload_value;
    logic        clk_div_request;
    logic        disable_request;
    logic        clk_div_status;
    logic        disabled_status;
    logic        timeout_mode_flag;
    logic        prewarning_flag;
    logic [15:0] live_count;
    logic [13:0] prediv;
    logic [11:0] prewarn_cnt;
    logic        nmi;
    logic        rst_req;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } wdt_state_s;

  typedef struct packed {
    logic access_error_flag;
    logic overflow_error_flag;
  } wdt_err_s;

endpackage : wdt_pkg

// ===== logic/password_guarded_watchdog_regs.sv
// Purpose: Password guarded watchdog with APB register access
// Assumes: pclk 40 MHz; presetn is every reset, cold_resetn all but the watchdog one
// Notes:   One wait state on every APB access
`include "wdt_consts.svh"

module password_guarded_watchdog_regs
  import wdt_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        cold_resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             init_done_protect_bit,
  output logic             nmi_trap,
  output logic             chip_reset_req
);

  wdt_state_s s_reg;
  wdt_state_s s_next;
  wdt_err_s   e_reg;
  wdt_err_s   e_next;

  logic        hit_access;
  logic        hit_mode;
  logic        hit_status;
  logic        wr_done;
  logic        pass_ok;
  logic        modify_ok;
  logic        pass_ev;
  logic        modify_ev;
  logic        term_ev;
  logic        acc_err_ev;
  logic        tick;
  logic        ovf_ev;
  logic        err_ev;
  logic        run;

  assign hit_access = paddr == (`WDT_BASE_ADDR + `WDT_OFS_ACCESS);
  assign hit_mode   = paddr == (`WDT_BASE_ADDR + `WDT_OFS_MODE);
  assign hit_status = paddr == (`WDT_BASE_ADDR + `WDT_OFS_STATUS);
  assign wr_done    = psel && penable && s_reg.pready && pwrite;

  // Written lock bit is compared only, never stored
  assign pass_ok = pwdata[`WDT_POS_PROTECT] == s_reg.endinit
                && !pwdata[`WDT_POS_LOCK]
                && pwdata[3:2] == {s_reg.disable_request,
                                   s_reg.clk_div_request}
                && pwdata[7:4] == `WDT_HW_PASS_HIGH
                && pwdata[15:8] == s_reg.user_password
                && pwdata[31:16] == s_reg.reload_value;
  assign modify_ok = pwdata[`WDT_POS_LOCK]
                  && pwdata[3:2] == 2'h0
                  && pwdata[7:4] == `WDT_HW_PASS_HIGH;

  assign pass_ev    = wr_done && hit_access && s_reg.lock && pass_ok;
  assign modify_ev  = wr_done && hit_access && !s_reg.lock && modify_ok;
  assign term_ev    = modify_ev && pwdata[`WDT_POS_PROTECT];
  assign acc_err_ev = wr_done && hit_access
                   && (s_reg.lock ? !pass_ok : !modify_ok);

  assign tick = s_reg.clk_div_status ? ((s_reg.prediv & `WDT_FAST_MASK) == `WDT_FAST_MASK)
                                     : (s_reg.prediv == `WDT_SLOW_MASK);
  // Time-out mode runs even when disabled, so a late modify still trips
  assign run    = (s_reg.timeout_mode_flag || !s_reg.disabled_status)
               && !s_reg.prewarning_flag;
  assign ovf_ev = tick && run && s_reg.live_count == 16'hffff;
  assign err_ev = ovf_ev || acc_err_ev;

  always_comb begin
    s_next         = s_reg;
    e_next         = e_reg;
    s_next.nmi     = 1'b0;
    s_next.pslverr = 1'b0;
    s_next.pready  = psel && penable && !s_reg.pready;
    s_next.prediv  = s_reg.prediv + 14'h0001;
    s_next.prdata  = s_reg.prdata;

    if (tick && run) begin
      s_next.live_count = s_reg.live_count + 16'h0001;
    end

    if (pass_ev) begin
      s_next.lock              = 1'b0;
      s_next.timeout_mode_flag = 1'b1;
      s_next.live_count        = `WDT_TIMEOUT_START;
    end

    // A failed modify relocks too, so the next try needs a fresh password
    if (wr_done && hit_access && !s_reg.lock) begin
      s_next.lock = 1'b1;
    end

    if (modify_ev) begin
      s_next.endinit       = pwdata[`WDT_POS_PROTECT];
      s_next.user_password = pwdata[15:8];
      s_next.reload_value  = pwdata[31:16];
    end

    if (term_ev) begin
      s_next.timeout_mode_flag = 1'b0;
      s_next.clk_div_status    = s_reg.clk_div_request;
      s_next.disabled_status   = s_reg.disable_request;
      s_next.live_count        = pwdata[31:16];
      if (!s_reg.prewarning_flag) begin
        e_next.access_error_flag   = 1'b0;
        e_next.overflow_error_flag = 1'b0;
      end
    end

    if (wr_done && hit_mode && !s_reg.endinit) begin
      s_next.clk_div_request = pwdata[`WDT_POS_DIV];
      s_next.disable_request = pwdata[`WDT_POS_DIS];
    end

    // Set after clear so a same-cycle event is never lost
    if (acc_err_ev) begin
      e_next.access_error_flag = 1'b1;
    end
    if (ovf_ev) begin
      e_next.overflow_error_flag = 1'b1;
    end

    if (s_reg.prewarning_flag) begin
      if (s_reg.prewarn_cnt != 12'h000) begin
        s_next.prewarn_cnt = s_reg.prewarn_cnt - 12'h001;
      end else begin
        s_next.rst_req = 1'b1;
      end
    end else if (err_ev) begin
      s_next.prewarning_flag   = 1'b1;
      s_next.nmi               = 1'b1;
      s_next.prewarn_cnt       = `WDT_PREWARN_CYCLES;
      s_next.timeout_mode_flag = s_reg.timeout_mode_flag | s_next.timeout_mode_flag;
    end

    if (psel && penable && !s_reg.pready) begin
      s_next.prdata = 32'h0000_0000;
      if (!pwrite && hit_access) begin
        s_next.prdata = {s_reg.reload_value, s_reg.user_password, 6'h00,
                         s_reg.lock, s_reg.endinit};
      end else if (!pwrite && hit_mode) begin
        s_next.prdata = {28'h0000000, s_reg.disable_request,
                         s_reg.clk_div_request, 2'h0};
      end else if (!pwrite && hit_status) begin
        s_next.prdata = {s_reg.live_count, 10'h000,
                         s_reg.prewarning_flag, s_reg.timeout_mode_flag,
                         s_reg.disabled_status, s_reg.clk_div_status,
                         e_reg.overflow_error_flag,
                         e_reg.access_error_flag};
      end
      s_next.pslverr = !(hit_access || hit_mode || hit_status);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg.endinit           <= 1'b0;
      s_reg.lock              <= 1'b1;
      s_reg.user_password     <= `WDT_USER_PW_RESET;
      s_reg.reload_value      <= `WDT_RELOAD_RESET;
      s_reg.clk_div_request   <= 1'b0;
      s_reg.disable_request   <= 1'b0;
      s_reg.clk_div_status    <= 1'b0;
      s_reg.disabled_status   <= 1'b0;
      s_reg.timeout_mode_flag <= 1'b1;
      s_reg.prewarning_flag   <= 1'b0;
      s_reg.live_count        <= `WDT_TIMEOUT_START;
      s_reg.prediv            <= 14'h0000;
      s_reg.prewarn_cnt       <= 12'h000;
      s_reg.nmi               <= 1'b0;
      s_reg.rst_req           <= 1'b0;
      s_reg.pready            <= 1'b0;
      s_reg.pslverr           <= 1'b0;
      s_reg.prdata            <= 32'h0000_0000;
    end else begin
      s_reg <= s_next;
    end
  end

  // Error flags sit on the cold reset so a watchdog reset leaves them
  always_ff @(posedge pclk or negedge cold_resetn) begin
    if (!cold_resetn) begin
      e_reg <= '0;
    end else begin
      e_reg <= e_next;
    end
  end

  assign prdata                = s_reg.prdata;
  assign pready                = s_reg.pready;
  assign pslverr               = s_reg.pslverr;
  assign init_done_protect_bit = s_reg.endinit;
  assign nmi_trap              = s_reg.nmi;
  assign chip_reset_req        = s_reg.rst_req;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn || !cold_resetn);

  pass_unlock_a: assert property (
      pass_ev |=> !s_reg.lock && s_reg.timeout_mode_flag)
    else $error("password access did not unlock into time-out");

  modify_relock_a: assert property (
      modify_ev |=> s_reg.lock)
    else $error("modify access did not relock");

  div_copy_a: assert property (
      term_ev |=> s_reg.clk_div_status == $past(s_reg.clk_div_request)
                  && s_reg.disabled_status == $past(s_reg.disable_request)
                  && !s_reg.timeout_mode_flag)
    else $error("terminating modify did not copy requests");

  status_hold_a: assert property (
      !term_ev |=> $stable(s_reg.clk_div_status) && $stable(s_reg.disabled_status))
    else $error("status bit changed without terminating modify");

  mode_guard_a: assert property (
      wr_done && hit_mode && s_reg.endinit
      |=> $stable(s_reg.disable_request) && $stable(s_reg.clk_div_request))
    else $error("mode request written while protected");

  reload_guard_a: assert property (
      !modify_ev |=> $stable(s_reg.reload_value))
    else $error("reload value changed outside modify");

  overflow_set_a: assert property (
      ovf_ev |=> e_reg.overflow_error_flag && s_reg.live_count == 16'h0000)
    else $error("wrap did not set overflow flag");

  access_err_a: assert property (
      acc_err_ev |=> e_reg.access_error_flag)
    else $error("illegal access not flagged");

  prewarn_entry_a: assert property (
      err_ev && !s_reg.prewarning_flag
      |=> s_reg.prewarning_flag && nmi_trap ##1 !nmi_trap)
    else $error("error did not raise one-cycle trap");

  prewarn_keep_a: assert property (
      s_reg.prewarning_flag && e_reg.access_error_flag |=> e_reg.access_error_flag)
    else $error("access error cleared during prewarning");

  count_step_a: assert property (
      tick && run && !pass_ev && !term_ev
      |=> s_reg.live_count == $past(s_reg.live_count) + 16'h0001)
    else $error("counter did not step on tick");

  status_zero_a: assert property (
      psel && penable && !s_reg.pready && !pwrite && hit_status
      |=> pready && prdata[15:6] == 10'h000 && prdata[31:16] == $past(s_reg.live_count))
    else $error("status read shows wrong fields");

  access_read_a: assert property (
      psel && penable && !s_reg.pready && !pwrite && hit_access
      |=> prdata[7:2] == 6'h00 && prdata[1] == $past(s_reg.lock))
    else $error("access control read shows password bits");

  mode_read_a: assert property (
      psel && penable && !s_reg.pready && !pwrite && hit_mode
      |=> prdata[31:4] == 28'h0000000 && prdata[1:0] == 2'h0)
    else $error("mode control read shows unused bits");

  unmapped_err_a: assert property (
      psel && penable && !s_reg.pready && !(hit_access || hit_mode || hit_status)
      |=> pready && pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");

  status_write_a: assert property (
      psel && penable && !s_reg.pready && hit_status |=> pready && !pslverr)
    else $error("status access answered with an error");

  ready_pulse_a: assert property (
      psel && penable && !pready |=> pready ##1 !pready)
    else $error("ready is not a single wait-state pulse");

  reload_restart_a: assert property (
      term_ev |=> s_reg.live_count == $past(pwdata[31:16]))
    else $error("service did not restart from reload");

  pass_restart_a: assert property (
      pass_ev |=> s_reg.live_count == `WDT_TIMEOUT_START)
    else $error("password access did not start time-out count");

  protect_store_a: assert property (
      modify_ev |=> init_done_protect_bit == $past(pwdata[`WDT_POS_PROTECT]))
    else $error("protect bit not taken from modify");

  pass_keep_a: assert property (
      pass_ev |=> $stable(init_done_protect_bit))
    else $error("protect bit changed by password access");

  user_pw_store_a: assert property (
      modify_ev |=> s_reg.user_password == $past(pwdata[15:8]))
    else $error("user password not taken from modify");

  fail_relock_a: assert property (
      acc_err_ev |=> s_reg.lock && $stable(s_reg.endinit))
    else $error("illegal access left the register open");

  timeout_keep_a: assert property (
      err_ev && s_reg.timeout_mode_flag |=> s_reg.timeout_mode_flag)
    else $error("error during time-out cleared the flag");

  err_clear_a: assert property (
      term_ev && !s_reg.prewarning_flag && !err_ev
      |=> !e_reg.access_error_flag && !e_reg.overflow_error_flag)
    else $error("error flags survived a terminating modify");

  ovf_keep_a: assert property (
      s_reg.prewarning_flag && e_reg.overflow_error_flag |=> e_reg.overflow_error_flag)
    else $error("overflow error cleared during prewarning");

  acc_set_only_a: assert property (
      !e_reg.access_error_flag && !acc_err_ev |=> !e_reg.access_error_flag)
    else $error("access error flag set without illegal access");

  ovf_set_only_a: assert property (
      !e_reg.overflow_error_flag && !ovf_ev |=> !e_reg.overflow_error_flag)
    else $error("overflow flag set without wrap");

  count_halt_a: assert property (
      !run && !pass_ev && !term_ev |=> $stable(s_reg.live_count))
    else $error("counter moved while halted");

  chip_reset_a: assert property (
      s_reg.prewarning_flag && s_reg.prewarn_cnt == 12'h000 |=> chip_reset_req)
    else $error("prewarning end did not request chip reset");

  reset_hold_a: assert property (
      chip_reset_req |=> chip_reset_req && s_reg.prewarning_flag)
    else $error("chip reset request dropped");

  mode_write_a: assert property (
      wr_done && hit_mode && !s_reg.endinit
      |=> s_reg.clk_div_request == $past(pwdata[`WDT_POS_DIV])
          && s_reg.disable_request == $past(pwdata[`WDT_POS_DIS]))
    else $error("open mode write not stored");

  fast_tick_a: assert property (
      tick && s_reg.clk_div_status |-> ##256 (tick || !s_reg.clk_div_status))
    else $error("fast tick spacing is not 256 cycles");

endmodule : password_guarded_watchdog_regs

// ===== sim/tb.sv
// Purpose: Self-checking bench for the password guarded watchdog registers
// Assumes: Prewarning lasts 2048 pclk cycles; APB waits on pready, not a fixed count
// Notes:   Overflow is reached with reload fffe at the fast divider
`include "wdt_consts.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import wdt_pkg::*;

  logic        pclk;
  logic        presetn;
  logic        cold_resetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        init_done_protect_bit;
  logic        nmi_trap;
  logic        chip_reset_req;
  int          mismatches = 0;
  int          cmp_count  = 0;
  int          cyc        = 0;
  logic [31:0] rd_data;
  logic        rd_err;

  localparam logic [31:0] ACC = `WDT_BASE_ADDR + `WDT_OFS_ACCESS;
  localparam logic [31:0] MOD = `WDT_BASE_ADDR + `WDT_OFS_MODE;
  localparam logic [31:0] STA = `WDT_BASE_ADDR + `WDT_OFS_STATUS;

  password_guarded_watchdog_regs dut_u (
    .pclk                  (pclk),
    .presetn               (presetn),
    .cold_resetn           (cold_resetn),
    .psel                  (psel),
    .penable               (penable),
    .pwrite                (pwrite),
    .paddr                 (paddr),
    .pwdata                (pwdata),
    .prdata                (prdata),
    .pready                (pready),
    .pslverr               (pslverr),
    .init_done_protect_bit (init_done_protect_bit),
    .nmi_trap              (nmi_trap),
    .chip_reset_req        (chip_reset_req)
  );

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish

  // Hang guard, generous over the few thousand cycles the run needs
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // Request held until pready is seen high at a rising edge; data taken there
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd_data = prdata;
    rd_err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input string name, input logic [31:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(name, rd_data, exp);
  endtask : rd

  task automatic do_reset(input logic cold);
    @(posedge pclk);
    presetn     <= 1'b0;
    cold_resetn <= ~cold;
    repeat (10) @(posedge pclk);
    presetn     <= 1'b1;
    cold_resetn <= 1'b1;
  endtask : do_reset

  initial begin
    int n;
    presetn     = 1'b0;
    cold_resetn = 1'b0;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 32'h0000_0000;
    pwdata      = 32'h0000_0000;
    do_reset(1'b1);
    rd("access", ACC, 32'hfffc_0002);
    rd("status", STA, 32'hfffc_0010);
    chk("protect", {31'h0, init_done_protect_bit}, 32'h0000_0000);
    apb(1'b0, `WDT_BASE_ADDR + 32'h0000_002c, 32'h0);
    chk("unmapped", {rd_err, rd_data[30:0]}, 32'h8000_0000);
    $display("Test reset and decode done");
    // Open window: request fast divider, status must not follow yet
    apb(1'b1, MOD, 32'h0000_0004);
    rd("mode", MOD, 32'h0000_0004);
    rd("status_old", STA, 32'hfffc_0010);
    apb(1'b1, ACC, 32'hfffc_00f4);
    rd("unlocked", ACC, 32'hfffc_0000);
    rd("timeout_on", STA, 32'hfffc_0010);
    // Terminating modify with a reload two steps short of wrap
    apb(1'b1, ACC, 32'hfffe_5af3);
    rd("locked", ACC, 32'hfffe_5a03);
    chk("protect", {31'h0, init_done_protect_bit}, 32'h0000_0001);
    apb(1'b1, MOD, 32'h0000_0000);
    rd("mode_held", MOD, 32'h0000_0004);
    $display("Test password and modify done");
    // Two fast ticks wrap the count; bound covers the free prescaler phase
    for (n = 0; n < 1000 && nmi_trap !== 1'b1; n++) @(negedge pclk);
    chk("nmi", {31'h0, nmi_trap}, 32'h0000_0001);
    rd("overflow", STA, 32'h0000_0026);
    // Lock bit written as 1 spoils the password
    apb(1'b1, ACC, 32'hfffe_5af7);
    rd("acc_err", STA, 32'h0000_0027);
    for (n = 0; n < 3000 && chip_reset_req !== 1'b1; n++) @(negedge pclk);
    chk("chip_rst", {31'h0, chip_reset_req}, 32'h0000_0001);
    $display("Test overflow and prewarning done");
    do_reset(1'b0);
    rd("wdt_rst", STA, 32'hfffc_0013);
    chk("rst_req", {31'h0, chip_reset_req}, 32'h0000_0000);
    do_reset(1'b1);
    rd("cold_rst", STA, 32'hfffc_0010);
    $display("Test reset kinds done");
    // Disable request, then a stale user password on a clean start
    apb(1'b1, MOD, 32'h0000_0008);
    apb(1'b1, ACC, 32'hfffc_00f8);
    apb(1'b1, ACC, 32'hfffc_11f3);
    rd("disabled", STA, 32'hfffc_0008);
    apb(1'b1, ACC, 32'hfffc_00f9);
    rd("pw_kept", ACC, 32'hfffc_1103);
    rd("pw_err", STA, 32'hfffc_0029);
    $display("Test disable and stale password done");
    tally_and_finish();
  end
endmodule : tb
